/* rtl/ppr_in_select.sv */
module ppr_in_select
    import ppr_pkg::*;
(
    input  wire logic [ppr_pkg::IN_SEL_W-1:0] sel_i,
    input  wire logic                         input_only_pin_181_i,
    input  wire logic                         comparator_one_output_i,
    output logic                              rx2_o
);
    import ppr_pkg::*;

    always_comb begin
        case (sel_i)
            SRC_PIN_181:      rx2_o = input_only_pin_181_i;
            SRC_COMPARATOR_1: rx2_o = comparator_one_output_i;
            SRC_GROUND:       rx2_o = 1'h0;
            // codes with no source wired here also read as ground
            default:          rx2_o = 1'h0;
        endcase
    end

endmodule : ppr_in_select

/* rtl/ppr_out_pin.sv */
module ppr_out_pin
    import ppr_pkg::*;
#(
    parameter int NUM_FN = 64
) (
    input  wire logic [ppr_pkg::FN_SEL_W-1:0] fn_sel_i,
    input  wire logic [NUM_FN-1:0]            periph_out_i,
    input  wire logic                         port_data_i,
    output logic                              pin_o,
    output logic                              periph_owned_o
);
    import ppr_pkg::*;

    always_comb begin
        periph_owned_o = (fn_sel_i != FN_PORT_CONTROL);
        if (periph_owned_o && (int'(fn_sel_i) < NUM_FN)) begin
            pin_o = periph_out_i[fn_sel_i];
        end else begin
            pin_o = port_data_i;
        end
    end

endmodule : ppr_out_pin

/* rtl/ppr_pkg.sv */
package ppr_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int          ADDR_W           = 4;
    localparam int          DATA_W           = 16;
    localparam int          IN_SEL_W         = 8;
    localparam int          FN_SEL_W         = 6;
    localparam int          NUM_OUT_REGS     = 3;
    localparam int          NUM_OUT_PINS     = 6;

    localparam logic [3:0]  ADDR_IN2_SELECT  = 4'h0;
    localparam logic [3:0]  ADDR_OUT_MAP_0   = 4'h1;
    localparam logic [3:0]  ADDR_OUT_MAP_1   = 4'h2;
    localparam logic [3:0]  ADDR_OUT_MAP_2   = 4'h3;

    // ****************************************
    // field layout
    // ****************************************
    localparam int          IN_SEL_LSB       = 0;
    localparam int          FN_LO_LSB        = 0;
    localparam int          FN_HI_LSB        = 8;

    localparam logic [7:0]  IN_SEL_RESET     = 8'h00;
    localparam logic [5:0]  FN_SEL_RESET     = 6'h00;
    localparam logic [15:0] READ_ZERO        = 16'h0000;

    // ****************************************
    // input source codes and output port-control function code
    // ****************************************
    localparam logic [7:0]  SRC_GROUND       = 8'h00;
    localparam logic [7:0]  SRC_COMPARATOR_1 = 8'h01;
    localparam logic [7:0]  SRC_PIN_181      = 8'hB5;

    localparam logic [5:0]  FN_PORT_CONTROL  = 6'h00;

endpackage : ppr_pkg

/* rtl/ppr_remap.sv */
// Strobed register access and the placing of the registers were decided locally.
module ppr_remap
    import ppr_pkg::*;
#(
    parameter int NUM_FN = 64
) (
    input  wire logic                            clk_sys_i,
    input  wire logic                            rst_b_i,
    input  wire logic [ppr_pkg::ADDR_W-1:0]      addr_i,
    input  wire logic [ppr_pkg::DATA_W-1:0]      wdata_i,
    input  wire logic                            wr_i,
    input  wire logic                            rd_i,
    output logic      [ppr_pkg::DATA_W-1:0]      rdata_o,
    input  wire logic                            input_only_pin_181_i,
    input  wire logic                            comparator_one_output_i,
    output logic                                 sensor_link_rx2_o,
    input  wire logic [NUM_FN-1:0]               periph_out_i,
    input  wire logic [ppr_pkg::NUM_OUT_PINS-1:0] port_data_i,
    output logic      [ppr_pkg::NUM_OUT_PINS-1:0] pin_o,
    output logic      [ppr_pkg::NUM_OUT_PINS-1:0] periph_owned_o
);
    import ppr_pkg::*;

    // ****************************************
    // select registers
    // ****************************************
    // pin order in outputs: 20, 35, 36, 37, 38, 39
    logic [IN_SEL_W-1:0] sensor_link_rx2_source;
    logic [FN_SEL_W-1:0] fn_sel [NUM_OUT_PINS];

    function automatic logic [DATA_W-1:0] pack_map(input logic [FN_SEL_W-1:0] hi,
                                                   input logic [FN_SEL_W-1:0] lo);
        pack_map = READ_ZERO;
        pack_map[FN_HI_LSB +: FN_SEL_W] = hi;
        pack_map[FN_LO_LSB +: FN_SEL_W] = lo;
    endfunction : pack_map

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sensor_link_rx2_source <= IN_SEL_RESET;
        end else if (wr_i && addr_i == ADDR_IN2_SELECT) begin
            // upper byte is not stored at all
            sensor_link_rx2_source <= wdata_i[IN_SEL_LSB +: IN_SEL_W];
        end
    end

    // map register k holds pin 2k+1 high and pin 2k low
    genvar k;
    generate
        for (k = 0; k < NUM_OUT_REGS; k++) begin : g_map
            localparam logic [ADDR_W-1:0] MAP_ADDR = ADDR_OUT_MAP_0 + ADDR_W'(k);
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    fn_sel[2*k]   <= FN_SEL_RESET;
                    fn_sel[2*k+1] <= FN_SEL_RESET;
                end else if (wr_i && addr_i == MAP_ADDR) begin
                    fn_sel[2*k+1] <= wdata_i[FN_HI_LSB +: FN_SEL_W];
                    fn_sel[2*k]   <= wdata_i[FN_LO_LSB +: FN_SEL_W];
                end
            end
        end
    endgenerate

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= READ_ZERO;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_IN2_SELECT: rdata_o <= DATA_W'(sensor_link_rx2_source);
                ADDR_OUT_MAP_0:  rdata_o <= pack_map(fn_sel[1], fn_sel[0]);
                ADDR_OUT_MAP_1:  rdata_o <= pack_map(fn_sel[3], fn_sel[2]);
                ADDR_OUT_MAP_2:  rdata_o <= pack_map(fn_sel[5], fn_sel[4]);
                default:         rdata_o <= READ_ZERO;
            endcase
        end else begin
            // data stands only in the cycle after the strobe
            rdata_o <= READ_ZERO;
        end
    end

    // ****************************************
    // routing
    // ****************************************
    ppr_in_select u_in_select (
        .sel_i                   (sensor_link_rx2_source),
        .input_only_pin_181_i    (input_only_pin_181_i),
        .comparator_one_output_i (comparator_one_output_i),
        .rx2_o                   (sensor_link_rx2_o)
    );

    genvar p;
    generate
        for (p = 0; p < NUM_OUT_PINS; p++) begin : g_pin
            ppr_out_pin #(
                .NUM_FN (NUM_FN)
            ) u_out_pin (
                .fn_sel_i       (fn_sel[p]),
                .periph_out_i   (periph_out_i),
                .port_data_i    (port_data_i[p]),
                .pin_o          (pin_o[p]),
                .periph_owned_o (periph_owned_o[p])
            );
        end
    endgenerate

endmodule : ppr_remap

/* sim/ppr_remap_checker.sv */
module ppr_remap_checker (
    input wire logic        clk_sys_i,
    input wire logic        rst_b_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        sensor_link_rx2_o,
    input wire logic [5:0]  port_data_i,
    input wire logic [5:0]  pin_o,
    input wire logic [5:0]  periph_owned_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // register and routing properties
    // ****************************************
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    AST_IN2_HI: assert property ($past(rd_i) && $past(addr_i) == 4'h0 |-> rdata_o[15:8] == 8'h00)
        else $error("select upper byte not zero");
    AST_IN2_RB: assert property (wr_i && addr_i == 4'h0 ##1 rd_i && addr_i == 4'h0
        |=> rdata_o[7:0] == $past(wdata_i[7:0], 2)) else $error("select readback wrong");
    AST_MAP_RSV: assert property ($past(rd_i) && $past(addr_i) inside {[4'h1:4'h3]}
        |-> {rdata_o[15:14], rdata_o[7:6]} == 4'h0) else $error("map reserved bits set");
    AST_MAP0: assert property (wr_i && addr_i == 4'h1
        |=> periph_owned_o[1:0] == {|$past(wdata_i[13:8]), |$past(wdata_i[5:0])})
        else $error("map 0 ownership wrong");
    AST_MAP1: assert property (wr_i && addr_i == 4'h2
        |=> periph_owned_o[3:2] == {|$past(wdata_i[13:8]), |$past(wdata_i[5:0])})
        else $error("map 1 ownership wrong");
    AST_MAP2: assert property (wr_i && addr_i == 4'h3
        |=> periph_owned_o[5:4] == {|$past(wdata_i[13:8]), |$past(wdata_i[5:0])})
        else $error("map 2 ownership wrong");
    AST_PORT: assert property (((pin_o ^ port_data_i) & ~periph_owned_o) == 6'h00)
        else $error("unowned pin not port data");
    AST_GND: assert property (wr_i && addr_i == 4'h0 && wdata_i[7:0] == 8'h00
        |=> !sensor_link_rx2_o) else $error("grounded input not low");
    AST_RST: assert property ($rose(rst_b_i) |-> periph_owned_o == 6'h00 && !sensor_link_rx2_o)
        else $error("selects not clear after reset");
endmodule : ppr_remap_checker

bind ppr_remap ppr_remap_checker u_chk (.clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .sensor_link_rx2_o, .port_data_i, .pin_o, .periph_owned_o);

/* sim/ppr_remap_tb_top.sv */
module ppr_remap_tb_top;
    import ppr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, rd_d = 0;
    logic        pin181 = 0, comparator_one_output = 0, rx2;
    logic [3:0]  addr_i = 0;
    logic [15:0] wdata_i = 0, rdata_o, m [4], exp_q [$];
    logic [63:0] periph = 0;
    logic [5:0]  port = 0, pin_o, owned;
    logic [31:0] lfsr = 32'h191D;
    int          error_cnt = 0, total_checks = 0, cyc = 0;

    ppr_remap #(.NUM_FN(64)) dut (.clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .input_only_pin_181_i(pin181), .comparator_one_output_i(comparator_one_output),
        .sensor_link_rx2_o(rx2),
        .periph_out_i(periph), .port_data_i(port), .pin_o, .periph_owned_o(owned));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk
    // model keeps only implemented bits, so readback expects zeros elsewhere
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        if (w && a < 4) m[a] = d & (a == 0 ? 16'h00FF : 16'h3F3F);
        if (!w) exp_q.push_back(a < 4 ? m[a] : 16'h0000);
    endtask : acc
    task automatic route;
        logic [5:0] f;
        for (int j = 0; j < 6; j++) begin
            f = j[0] ? m[1 + j / 2][13:8] : m[1 + j / 2][5:0];
            chk(pin_o[j], f != 0 ? periph[f] : port[j]);
            chk(owned[j], f != 0);
        end
        chk(rx2, m[0][7:0] == 8'h01 ? comparator_one_output :
                 m[0][7:0] == 8'hB5 ? pin181 : 1'b0);
    endtask : route
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // ****************************************
    // clock, monitor, stimulus
    // ****************************************
    initial forever #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) rd_d <= rd_i;
    // read data lives one cycle only: sample mid-cycle, clear of the edge
    always @(negedge clk_sys_i) if (rd_d) chk(rdata_o, exp_q.pop_front());
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            results;
        end
    end
    initial begin
        logic [3:0]  a;
        logic [15:0] d;
        for (int r = 0; r < 2; r++) begin
            // reset goes down on a rising edge like every other input
            @(posedge clk_sys_i);
            rst_b_i <= 0;
            repeat (12) @(posedge clk_sys_i);
            rst_b_i <= 1;
            m = '{default: 16'h0000};
            for (int k = 0; k < 6; k++) acc(0, 4'(k), 16'hFFFF);
            for (int i = 0; i < 40; i++) begin
                lfsr = nxt(lfsr);
                a = (i % 5 == 4) ? 4'hC : 4'(i % 5);
                d = lfsr[15:0];
                if (a == 0 && i % 20 < 15) d[7:0] = i % 20 < 5 ? 8'h00 : i % 20 < 10 ? 8'h01 : 8'hB5;
                acc(1, a, d);
                acc(0, a, d);
                @(posedge clk_sys_i);
                rd_i <= 0;
                periph <= {lfsr, ~lfsr};
                port <= lfsr[21:16];
                pin181 <= lfsr[30];
                comparator_one_output <= ~lfsr[30];
                @(negedge clk_sys_i);
                route;
            end
            $display("reset pass %0d done", r);
        end
        results;
    end
endmodule : ppr_remap_tb_top
